// ===== rtl/adm_path_defs.vh
// Constants for the ADM encoder path select block
`ifndef ADM_PATH_DEFS_VH
`define ADM_PATH_DEFS_VH

// ===========================================================
// Register offsets on the control bus
`define OFS_CODEC_IRQ_CTRL      8'h81
`define OFS_DEC_ADM_INPUT       8'hd8
`define OFS_ENC_MODE_SETUP      8'he0
`define OFS_ENC_OFFSET_LEVEL    8'he3
`define OFS_ENC_PCM_OUTPUT      8'he6
`define OFS_ENC_DAC_TEST        8'he7
`define OFS_ENC_ADM_INPUT       8'he8
`define OFS_ADM_REQ_STATUS      8'he9

// ===========================================================
// Encoder mode and setup field positions
`define FLD_DECIM_RATE          15
`define FLD_PCM_SEL_HI          14
`define FLD_PCM_SEL_LO          13
`define FLD_ADM_SEL_HI          12
`define FLD_ADM_SEL_LO          11
`define FLD_LDO_SEL_HI          10
`define FLD_LDO_SEL_LO          9
`define FLD_IDLE_ENH            8

// Interrupt control bit positions
`define FLD_IRQ_DEC_ADM         0
`define FLD_IRQ_ENC_ADM         1

// ===========================================================
// Field encodings
`define PCM_SEL_BURST           2'h2
`define PCM_SEL_HOST            2'h3
`define ADM_SEL_COMPARATOR      2'h0
`define ADM_SEL_HOST            2'h1
`define LDO_SEL_ESTIMATOR       2'h0
`define LDO_SEL_SUM             2'h1
`define LDO_SEL_DIRECT          2'h2
`define LDO_SEL_INTERP          2'h3

// ===========================================================
// Reset values
`define RST_MODE_SETUP          16'h0100
`define RST_WORD16              16'h0000
`define RST_IRQ_CTRL            2'h0

// ===========================================================
// Datapath sizes and counts
`define ADM_WORD_BITS           16
`define ADM_CNT_LAST            4'hf
`define DECIM_LAST_BY4          3'h3
`define DECIM_LAST_BY8          3'h7
`define DECIM_SHIFT_BY4         2
`define DECIM_SHIFT_BY8         3
`define INTERP_SHIFT            3
`define TRACK_SHIFT             8
`define PCM_MAX                 18'sh07fff
`define PCM_MIN                 18'sh38000

`endif

// ===== rtl/adm_bit_feeder.v
// Serialises a host-written ADM word one bit per codec bit period
`timescale 1ns/1ps

module adm_bit_feeder (
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_n_i,
    // Host side
    input  wire        load_i,
    input  wire [15:0] word_i,
    // Codec bit timing
    input  wire        tick_i,
    // Serial side
    output reg         bit_o,
    output reg         drained_o
);

`include "adm_path_defs.vh"

    reg [15:0] held;
    reg [15:0] shift;
    reg [3:0]  count;

    // ===========================================================
    // Shift out LSB first; the held word repeats so an idle pattern keeps playing
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            held      <= `RST_WORD16;
            shift     <= `RST_WORD16;
            count     <= 4'h0;
            bit_o     <= 1'b0;
            drained_o <= 1'b0;
        end else begin
            drained_o <= 1'b0;
            if (load_i) begin
                held <= word_i;
            end
            if (tick_i) begin
                bit_o <= shift[0];
                if (count == `ADM_CNT_LAST) begin
                    count     <= 4'h0;
                    shift     <= load_i ? word_i : held;
                    drained_o <= 1'b1;           // Word used up, host may refill
                end else begin
                    count <= count + 4'h1;
                    shift <= {1'b0, shift[15:1]};
                end
            end else if (load_i && count == 4'h0) begin
                shift <= word_i;                 // Fresh word at a word boundary
            end
        end
    end

endmodule

// ===== rtl/adm_encoder_path_select.v
// ADM codec encoder path select: setup registers, routing, PCM filter and offset tracking
`timescale 1ns/1ps

module adm_encoder_path_select (
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_n_i,
    // Control bus register port
    input  wire [7:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_write_i,
    input  wire        reg_read_i,
    output reg  [15:0] reg_rdata_o,
    output reg         reg_rvalid_o,
    // Codec bit timing
    input  wire        bit_tick_i,
    // Decoder side
    input  wire        dec_use_host_word_i,
    input  wire        dec_stream_bit_i,
    output reg         dec_adm_bit_o,
    // Encoder analog and estimator side
    input  wire        comparator_bit_i,
    input  wire [15:0] estimator_pcm_i,
    // Burst interface receive samples
    input  wire [15:0] burst_rx_pcm_i,
    input  wire        burst_rx_valid_i,
    // Encoder results
    output reg         enc_adm_bit_o,
    output reg         enc_loop_open_o,
    output reg         enc_interpolating_o,
    output reg  [15:0] local_decoder_pcm_o,
    output reg         direct_pcm_test_o,
    output reg         pcm_out_valid_o,
    output reg  [15:0] offset_estimate_o,
    // Host update requests
    output reg         dec_adm_irq_o,
    output reg         enc_adm_irq_o
);

`include "adm_path_defs.vh"

    // ===========================================================
    // Register state
    reg [15:0] mode_setup;          // Host view of the encoder setup word
    reg [15:0] mode_active;         // Copy applied to the datapath
    reg [15:0] dec_adm_word;
    reg [15:0] enc_adm_word;
    reg [15:0] offset_level;
    reg [15:0] dac_test_pcm;
    reg [15:0] pcm_output;
    reg [1:0]  irq_ctrl;
    reg        dec_adm_req;
    reg        enc_adm_req;

    // Datapath state
    reg [2:0]  decim_cnt;
    reg [18:0] decim_acc;
    reg [15:0] pcm_sample;
    reg [15:0] pcm_interp;
    reg [23:0] track_acc;

    wire       wr_dec_adm = reg_write_i && (reg_addr_i == `OFS_DEC_ADM_INPUT);
    wire       wr_enc_adm = reg_write_i && (reg_addr_i == `OFS_ENC_ADM_INPUT);
    wire       dec_feed_bit;
    wire       dec_drained;
    wire       enc_feed_bit;
    wire       enc_drained;

    // Active field decode
    wire       decim_by4   = mode_active[`FLD_DECIM_RATE];
    wire [1:0] pcm_sel     = mode_active[`FLD_PCM_SEL_HI:`FLD_PCM_SEL_LO];
    wire [1:0] adm_sel     = mode_active[`FLD_ADM_SEL_HI:`FLD_ADM_SEL_LO];
    wire [1:0] ldo_sel     = mode_active[`FLD_LDO_SEL_HI:`FLD_LDO_SEL_LO];
    wire       idle_enh    = mode_active[`FLD_IDLE_ENH];
    wire       interpolate = pcm_sel[1];

    // ===========================================================
    // Host ADM word serialisers
    adm_bit_feeder u_dec_feed (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .load_i    (wr_dec_adm),
        .word_i    (reg_wdata_i),
        .tick_i    (bit_tick_i),
        .bit_o     (dec_feed_bit),
        .drained_o (dec_drained)
    );

    adm_bit_feeder u_enc_feed (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .load_i    (wr_enc_adm),
        .word_i    (reg_wdata_i),
        .tick_i    (bit_tick_i),
        .bit_o     (enc_feed_bit),
        .drained_o (enc_drained)
    );

    // ===========================================================
    // Register writes
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_setup   <= `RST_MODE_SETUP;
            dec_adm_word <= `RST_WORD16;
            enc_adm_word <= `RST_WORD16;
            offset_level <= `RST_WORD16;
            dac_test_pcm <= `RST_WORD16;
            irq_ctrl     <= `RST_IRQ_CTRL;
        end else if (reg_write_i) begin
            case (reg_addr_i)
                `OFS_ENC_MODE_SETUP:   mode_setup   <= reg_wdata_i;
                `OFS_DEC_ADM_INPUT:    dec_adm_word <= reg_wdata_i;
                `OFS_ENC_ADM_INPUT:    enc_adm_word <= reg_wdata_i;
                `OFS_ENC_OFFSET_LEVEL: offset_level <= reg_wdata_i;
                `OFS_ENC_DAC_TEST:     dac_test_pcm <= reg_wdata_i;
                `OFS_CODEC_IRQ_CTRL:   irq_ctrl     <= reg_wdata_i[`FLD_IRQ_ENC_ADM:`FLD_IRQ_DEC_ADM];
                default: begin
                end
            endcase
        end
    end

    // ===========================================================
    // Setup word reaches the datapath only on a bit period boundary,
    // so a routing change never splits one codec bit between two paths
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_active <= `RST_MODE_SETUP;
        end else if (bit_tick_i) begin
            mode_active <= mode_setup;
        end
    end

    // ===========================================================
    // Register reads, one cycle after the strobe
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o  <= `RST_WORD16;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_read_i;
            if (reg_read_i) begin
                case (reg_addr_i)
                    `OFS_ENC_MODE_SETUP:   reg_rdata_o <= mode_setup;
                    `OFS_DEC_ADM_INPUT:    reg_rdata_o <= dec_adm_word;
                    `OFS_ENC_ADM_INPUT:    reg_rdata_o <= enc_adm_word;
                    `OFS_ENC_OFFSET_LEVEL: reg_rdata_o <= offset_level;
                    `OFS_ENC_DAC_TEST:     reg_rdata_o <= dac_test_pcm;
                    `OFS_ENC_PCM_OUTPUT:   reg_rdata_o <= pcm_output;
                    `OFS_CODEC_IRQ_CTRL:   reg_rdata_o <= {14'h0000, irq_ctrl};
                    `OFS_ADM_REQ_STATUS:   reg_rdata_o <= {14'h0000, enc_adm_req, dec_adm_req};
                    default:               reg_rdata_o <= `RST_WORD16;
                endcase
            end
        end
    end

    // ===========================================================
    // Refill requests: a drained word sets the flag, a write clears it,
    // and a drain in the same cycle as the write wins
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dec_adm_req   <= 1'b0;
            enc_adm_req   <= 1'b0;
            dec_adm_irq_o <= 1'b0;
            enc_adm_irq_o <= 1'b0;
        end else begin
            if (dec_drained) begin
                dec_adm_req <= 1'b1;
            end else if (wr_dec_adm) begin
                dec_adm_req <= 1'b0;
            end
            if (enc_drained) begin
                enc_adm_req <= 1'b1;
            end else if (wr_enc_adm) begin
                enc_adm_req <= 1'b0;
            end
            dec_adm_irq_o <= irq_ctrl[`FLD_IRQ_DEC_ADM] && (dec_drained || (dec_adm_req && !wr_dec_adm));
            enc_adm_irq_o <= irq_ctrl[`FLD_IRQ_ENC_ADM] && (enc_drained || (enc_adm_req && !wr_enc_adm));
        end
    end

    // ===========================================================
    // Decoder input: the host word, which may hold an idle pattern,
    // or the normal received stream
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dec_adm_bit_o <= 1'b0;
        end else if (bit_tick_i) begin
            dec_adm_bit_o <= dec_use_host_word_i ? dec_feed_bit : dec_stream_bit_i;
        end
    end

    // ===========================================================
    // PCM filter source: burst samples or the host test word
    reg [15:0] next_sample;
    always @* begin
        next_sample = pcm_sample;
        if (pcm_sel == `PCM_SEL_BURST && burst_rx_valid_i) begin
            next_sample = burst_rx_pcm_i;
        end else if (pcm_sel == `PCM_SEL_HOST) begin
            next_sample = dac_test_pcm;
        end
    end

    // ===========================================================
    // PCM filter: decimate the estimator, or interpolate the sample
    // with a one-pole smoother (cheap, but softens fast steps)
    wire [18:0] decim_sum  = decim_acc + {{3{estimator_pcm_i[15]}}, estimator_pcm_i};
    wire [2:0]  decim_last = decim_by4 ? `DECIM_LAST_BY4 : `DECIM_LAST_BY8;
    wire [18:0] decim_avg  = decim_by4 ? ($signed(decim_sum) >>> `DECIM_SHIFT_BY4)
                                       : ($signed(decim_sum) >>> `DECIM_SHIFT_BY8);
    wire [16:0] interp_err = {pcm_sample[15], pcm_sample} - {pcm_interp[15], pcm_interp};
    wire [16:0] interp_stp = $signed(interp_err) >>> `INTERP_SHIFT;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            decim_cnt       <= 3'h0;
            decim_acc       <= 19'h00000;
            pcm_output      <= `RST_WORD16;
            pcm_out_valid_o <= 1'b0;
            pcm_sample      <= `RST_WORD16;
            pcm_interp      <= `RST_WORD16;
        end else begin
            pcm_out_valid_o <= 1'b0;
            pcm_sample      <= next_sample;
            if (bit_tick_i) begin
                if (!interpolate) begin
                    if (decim_cnt >= decim_last) begin
                        decim_cnt       <= 3'h0;
                        decim_acc       <= 19'h00000;
                        pcm_output      <= decim_avg[15:0];
                        pcm_out_valid_o <= 1'b1;
                    end else begin
                        decim_cnt <= decim_cnt + 3'h1;
                        decim_acc <= decim_sum;
                    end
                end else begin
                    decim_cnt  <= 3'h0;
                    decim_acc  <= 19'h00000;
                    pcm_interp <= pcm_interp + interp_stp[15:0];
                end
            end
        end
    end

    // ===========================================================
    // ADM encoder input select
    wire       fb_bit = ($signed(pcm_interp) >= $signed(estimator_pcm_i));
    reg        next_enc_bit;
    always @* begin
        case (adm_sel)
            `ADM_SEL_COMPARATOR: next_enc_bit = comparator_bit_i;
            `ADM_SEL_HOST:       next_enc_bit = enc_feed_bit;
            default:             next_enc_bit = fb_bit;
        endcase
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            enc_adm_bit_o       <= 1'b0;
            enc_loop_open_o     <= 1'b0;
            enc_interpolating_o <= 1'b0;
        end else begin
            if (bit_tick_i) begin
                enc_adm_bit_o <= next_enc_bit;
            end
            enc_loop_open_o     <= (adm_sel == `ADM_SEL_HOST);
            enc_interpolating_o <= interpolate;
        end
    end

    // ===========================================================
    // Local decoder output select
    wire [17:0] est_ext   = {{2{estimator_pcm_i[15]}}, estimator_pcm_i};
    wire [17:0] interp_ex = {{2{pcm_interp[15]}}, pcm_interp};
    wire [17:0] sample_ex = {{2{pcm_sample[15]}}, pcm_sample};
    wire [17:0] level_ex  = {{2{offset_level[15]}}, offset_level};
    wire [17:0] track_ex  = {{2{track_acc[23]}}, track_acc[23:8]};
    reg  [17:0] ldo_raw;
    reg  [17:0] next_ldo;

    always @* begin
        case (ldo_sel)
            `LDO_SEL_ESTIMATOR: ldo_raw = est_ext;
            `LDO_SEL_SUM:       ldo_raw = est_ext + interp_ex;
            `LDO_SEL_DIRECT:    ldo_raw = sample_ex;
            default:            ldo_raw = interp_ex;
        endcase
        // Programmed level always applies; tracked offset only when enhance is set
        next_ldo = idle_enh ? (ldo_raw + level_ex - track_ex) : (ldo_raw + level_ex);
        if ($signed(next_ldo) > $signed(`PCM_MAX)) begin
            next_ldo = `PCM_MAX;
        end else if ($signed(next_ldo) < $signed(`PCM_MIN)) begin
            next_ldo = `PCM_MIN;
        end
    end

    // ===========================================================
    // Offset tracker: slow leaky average of the routed signal; it is
    // frozen and cleared with enhance off so no stale offset lingers
    wire [23:0] ldo_wide  = {{6{ldo_raw[17]}}, ldo_raw};
    wire [23:0] track_err = ldo_wide - ({{8{track_acc[23]}}, track_acc[23:8]});

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            track_acc           <= 24'h000000;
            local_decoder_pcm_o <= `RST_WORD16;
            direct_pcm_test_o   <= 1'b0;
            offset_estimate_o   <= `RST_WORD16;
        end else begin
            if (!idle_enh) begin
                track_acc <= 24'h000000;
            end else if (bit_tick_i) begin
                track_acc <= track_acc + track_err;
            end
            if (bit_tick_i) begin
                local_decoder_pcm_o <= next_ldo[15:0];
            end
            direct_pcm_test_o <= (ldo_sel == `LDO_SEL_DIRECT);
            offset_estimate_o <= track_ex[15:0];
        end
    end

endmodule

// ===== bench/codec_tick_model.sv
// Codec-side stand-in: bit period ticks and a comparator bit stream
`timescale 1ns/1ps

module codec_tick_model (
    // Clock and reset
    input  wire clk_i,
    input  wire reset_n_i,
    // Bit timing and comparator
    output reg  bit_tick_o,
    output reg  comparator_bit_o
);
    reg [2:0] phase;

    // One tick every eight cycles, held off in reset so the first period is whole
    always @(negedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase <= 3'h0;
            bit_tick_o <= 1'b0;
            comparator_bit_o <= 1'b0;
        end else begin
            phase <= phase + 3'h1;
            bit_tick_o <= (phase == 3'h7);
            // Toggle with each tick so a stuck encoder bit shows at once
            if (phase == 3'h7) begin
                comparator_bit_o <= ~comparator_bit_o;
            end
        end
    end
endmodule

// ===== bench/adm_path_select_properties.sv
// Concurrent checks on the ports of the ADM encoder path select block
`timescale 1ns/1ps
`include "adm_path_defs.vh"

module adm_path_select_properties (
    // Clock and reset
    input wire        clk_i,
    input wire        reset_n_i,
    // Register port
    input wire [7:0]  reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire        reg_write_i,
    input wire        reg_read_i,
    input wire        reg_rvalid_o,
    // Datapath
    input wire        bit_tick_i,
    input wire        comparator_bit_i,
    input wire        enc_adm_bit_o,
    input wire        enc_loop_open_o,
    input wire        enc_interpolating_o,
    input wire        direct_pcm_test_o,
    input wire        pcm_out_valid_o,
    input wire        dec_adm_irq_o
);
    reg [15:0] mode_w;
    reg [15:0] mode_a;
    reg        irq_en;
    reg [3:0]  tcnt;
    reg        chg;

    // Shadow of the setup word; chg blocks the one window a mode change may cut short
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_w <= `RST_MODE_SETUP;
            mode_a <= `RST_MODE_SETUP;
            irq_en <= 1'b0;
            tcnt <= 4'h0;
            chg <= 1'b0;
        end else begin
            if (reg_write_i && reg_addr_i == `OFS_ENC_MODE_SETUP) mode_w <= reg_wdata_i;
            if (reg_write_i && reg_addr_i == `OFS_CODEC_IRQ_CTRL) irq_en <= reg_wdata_i[0];
            if (bit_tick_i) mode_a <= mode_w;
            if (pcm_out_valid_o) chg <= 1'b0;
            if (bit_tick_i && mode_w != mode_a) chg <= 1'b1;
            if (pcm_out_valid_o) tcnt <= {3'h0, bit_tick_i};
            else if (bit_tick_i) tcnt <= tcnt + 4'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_RD_ANSWER: assert property (reg_read_i |=> reg_rvalid_o) else $error("read not answered");
    AST_RD_QUIET: assert property (!reg_read_i |=> !reg_rvalid_o) else $error("spurious read valid");
    AST_DECIM_COUNT: assert property (pcm_out_valid_o && !chg && !mode_a[14] |->
        tcnt == (mode_a[15] ? 4'h4 : 4'h8)) else $error("wrong decimation count");
    AST_INTERP: assert property ($stable(mode_a) [*3] |-> enc_interpolating_o == mode_a[14])
        else $error("interpolate flag wrong");
    AST_COMPARATOR: assert property (bit_tick_i && mode_a[12:11] == 2'b00 |=>
        enc_adm_bit_o == $past(comparator_bit_i)) else $error("encoder bit not from comparator");
    AST_LOOP_OPEN: assert property ($stable(mode_a) [*3] |-> enc_loop_open_o == (mode_a[12:11] == 2'b01))
        else $error("loop open flag wrong");
    AST_DIRECT: assert property ($stable(mode_a) [*3] |-> direct_pcm_test_o == (mode_a[10:9] == 2'b10))
        else $error("direct test flag wrong");
    AST_IRQ_GATE: assert property (dec_adm_irq_o |-> $past(irq_en)) else $error("irq while disabled");

    COV_PCM_OUT: cover property (pcm_out_valid_o && mode_a[15]);
    COV_LOOP_OPEN: cover property (enc_loop_open_o);
    COV_IRQ: cover property (dec_adm_irq_o);
endmodule

bind adm_encoder_path_select adm_path_select_properties adm_path_select_properties_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rvalid_o(reg_rvalid_o),
    .bit_tick_i(bit_tick_i), .comparator_bit_i(comparator_bit_i), .enc_adm_bit_o(enc_adm_bit_o),
    .enc_loop_open_o(enc_loop_open_o), .enc_interpolating_o(enc_interpolating_o),
    .direct_pcm_test_o(direct_pcm_test_o), .pcm_out_valid_o(pcm_out_valid_o), .dec_adm_irq_o(dec_adm_irq_o)
);

// ===== bench/tb_adm_encoder_path_select.sv
// Register-level testbench for the ADM encoder path select block
`timescale 1ns/1ps
`include "adm_path_defs.vh"
`define CHK(got, exp) begin cmp_count = cmp_count + 1; if ((got) !== (exp)) begin errors = errors + 1; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_adm_encoder_path_select;
    reg         clk_i = 1'b0;
    reg         reset_n_i = 1'b0;
    reg  [7:0]  reg_addr_i = 8'h00;
    reg  [15:0] reg_wdata_i = 16'h0000;
    reg         reg_write_i = 1'b0;
    reg         reg_read_i = 1'b0;
    reg         dec_use_host_word_i = 1'b0;
    reg         dec_stream_bit_i = 1'b0;
    reg  [15:0] estimator_pcm_i = 16'h0000;
    wire [15:0] reg_rdata_o;
    wire        reg_rvalid_o, bit_tick_i, comparator_bit_i, dec_adm_bit_o, enc_adm_bit_o, enc_loop_open_o;
    wire        enc_interpolating_o, direct_pcm_test_o, pcm_out_valid_o, dec_adm_irq_o, enc_adm_irq_o;
    wire [15:0] local_decoder_pcm_o, offset_estimate_o;
    integer     errors = 0;
    integer     cmp_count = 0;
    integer     i;
    reg         prev;
    reg  [15:0] modes [0:3];
    reg  [2:0]  flags [0:3];

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    codec_tick_model codec_tick_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .bit_tick_o(bit_tick_i), .comparator_bit_o(comparator_bit_i));

    // Burst receive path is tied off; no burst framing is modelled here
    adm_encoder_path_select adm_encoder_path_select_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .bit_tick_i(bit_tick_i), .dec_use_host_word_i(dec_use_host_word_i), .dec_stream_bit_i(dec_stream_bit_i),
        .dec_adm_bit_o(dec_adm_bit_o), .comparator_bit_i(comparator_bit_i), .estimator_pcm_i(estimator_pcm_i),
        .burst_rx_pcm_i(16'h0000), .burst_rx_valid_i(1'b0), .enc_adm_bit_o(enc_adm_bit_o),
        .enc_loop_open_o(enc_loop_open_o), .enc_interpolating_o(enc_interpolating_o),
        .local_decoder_pcm_o(local_decoder_pcm_o), .direct_pcm_test_o(direct_pcm_test_o),
        .pcm_out_valid_o(pcm_out_valid_o), .offset_estimate_o(offset_estimate_o),
        .dec_adm_irq_o(dec_adm_irq_o), .enc_adm_irq_o(enc_adm_irq_o));

    // Writes start one cycle after a tick so a setup change never races the tick edge
    task reg_wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clk_i iff bit_tick_i);
            @(negedge clk_i);
            reg_addr_i = a;
            reg_wdata_i = d;
            reg_write_i = 1'b1;
            @(negedge clk_i);
            reg_write_i = 1'b0;
        end
    endtask

    // Read with strobe for one cycle, data taken once settled
    task check_rd(input [7:0] a, input [15:0] exp);
        begin
            @(negedge clk_i);
            reg_addr_i = a;
            reg_read_i = 1'b1;
            @(negedge clk_i);
            reg_read_i = 1'b0;
            `CHK(reg_rdata_o, exp)
        end
    endtask

    task wait_ticks(input integer n);
        begin
            repeat (n) @(posedge clk_i iff bit_tick_i);
            @(negedge clk_i);
        end
    endtask

    // Bounded wait for the next decimated sample strobe
    task wait_valid;
        integer k;
        begin
            k = 0;
            @(negedge clk_i);
            while (pcm_out_valid_o !== 1'b1 && k < 200) begin
                @(negedge clk_i);
                k = k + 1;
            end
            `CHK(pcm_out_valid_o, 1'b1)
        end
    endtask

    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask

    // Watchdog sized well beyond the thousand or so cycles the tests need
    initial begin
        #100000;
        errors = errors + 1;
        give_verdict;
    end

    initial begin
        modes[0] = 16'h5000; flags[0] = 3'b010;
        modes[1] = 16'h6400; flags[1] = 3'b011;
        modes[2] = 16'h1600; flags[2] = 3'b000;
        modes[3] = 16'h0800; flags[3] = 3'b100;
        repeat (20) @(negedge clk_i);
        reset_n_i = 1'b1;
        check_rd(`OFS_ENC_MODE_SETUP, `RST_MODE_SETUP);
        check_rd(8'h55, 16'h0000);
        check_rd(`OFS_DEC_ADM_INPUT, `RST_WORD16);
        $display("test reset done");
        // Tracking off with zero offset level before decoding ADM to PCM
        reg_wr(`OFS_ENC_OFFSET_LEVEL, 16'h0000);
        estimator_pcm_i = 16'h0040;
        reg_wr(`OFS_ENC_MODE_SETUP, 16'h8000);
        // The first strobe may close a window cut by the mode change
        wait_valid;
        wait_valid;
        check_rd(`OFS_ENC_PCM_OUTPUT, 16'h0040);
        estimator_pcm_i = 16'hfff0;
        reg_wr(`OFS_ENC_MODE_SETUP, 16'h0000);
        wait_valid;
        wait_valid;
        reg_wr(`OFS_ENC_PCM_OUTPUT, 16'h1234);
        check_rd(`OFS_ENC_PCM_OUTPUT, 16'hfff0);
        $display("test decimation done");
        dec_use_host_word_i = 1'b1;
        reg_wr(`OFS_DEC_ADM_INPUT, 16'h5555);
        check_rd(`OFS_DEC_ADM_INPUT, 16'h5555);
        // The new word starts playing at the next word boundary, up to 16 ticks away
        wait_ticks(17);
        for (i = 0; i < 4; i = i + 1) begin
            wait_ticks(1);
            prev = dec_adm_bit_o;
            wait_ticks(1);
            `CHK(dec_adm_bit_o, ~prev)
        end
        dec_use_host_word_i = 1'b0;
        dec_stream_bit_i = 1'b1;
        wait_ticks(2);
        `CHK(dec_adm_bit_o, 1'b1)
        $display("test decoder word done");
        reg_wr(`OFS_CODEC_IRQ_CTRL, 16'h0001);
        i = 0;
        while (dec_adm_irq_o !== 1'b1 && i < 300) begin
            @(negedge clk_i);
            i = i + 1;
        end
        `CHK(dec_adm_irq_o, 1'b1)
        reg_wr(`OFS_DEC_ADM_INPUT, 16'h5555);
        @(negedge clk_i);
        // A drain in the write's own cycle wins, so write once more a tick later
        if (dec_adm_irq_o === 1'b1) reg_wr(`OFS_DEC_ADM_INPUT, 16'h5555);
        @(negedge clk_i);
        `CHK(dec_adm_irq_o, 1'b0)
        reg_wr(`OFS_CODEC_IRQ_CTRL, 16'h0000);
        $display("test interrupt done");
        reg_wr(`OFS_ENC_ADM_INPUT, 16'hffff);
        for (i = 0; i < 4; i = i + 1) begin
            reg_wr(`OFS_ENC_MODE_SETUP, modes[i]);
            wait_ticks(2);
            `CHK({enc_loop_open_o, enc_interpolating_o, direct_pcm_test_o}, flags[i])
        end
        wait_ticks(16);
        `CHK(enc_adm_bit_o, 1'b1)
        reg_wr(`OFS_CODEC_IRQ_CTRL, 16'h0002);
        @(negedge clk_i);
        `CHK({enc_adm_irq_o, dec_adm_irq_o}, 2'b10)
        $display("test routing done");
        reg_wr(`OFS_ENC_OFFSET_LEVEL, 16'h0010);
        estimator_pcm_i = 16'h0123;
        reg_wr(`OFS_ENC_MODE_SETUP, 16'h0000);
        wait_ticks(2);
        `CHK(local_decoder_pcm_o, 16'h0133)
        reg_wr(`OFS_ENC_MODE_SETUP, 16'h6200);
        wait_ticks(2);
        `CHK(local_decoder_pcm_o, 16'h0133)
        `CHK(offset_estimate_o, 16'h0000)
        // Comparator feedback and a small positive level with compensation turned on
        reg_wr(`OFS_ENC_MODE_SETUP, 16'h0100);
        check_rd(`OFS_ENC_MODE_SETUP, 16'h0100);
        $display("test local output done");
        give_verdict;
    end
endmodule
